// [core/gpio_defs.svh]
// Purpose: Register indices and reset values of the GPIO bank.
// Assumes: Index lists pack one 7-bit index per port, port 1 in the low bits.
// Notes: The byte address of a register is four times its index.
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define IDX_IN {7'h39, 7'h38, 7'h34, 7'h30, 7'h1C, 7'h18, 7'h28, 7'h20}
`define IDX_OUT {7'h3B, 7'h3A, 7'h35, 7'h31, 7'h1D, 7'h19, 7'h29, 7'h21}
`define IDX_DIR {7'h3D, 7'h3C, 7'h36, 7'h32, 7'h1E, 7'h1A, 7'h2A, 7'h22}
`define IDX_SEL {7'h3F, 7'h3E, 7'h37, 7'h33, 7'h1F, 7'h1B, 7'h2E, 7'h26}
`define IDX_SEL2 {7'h48, 7'h47, 7'h46, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41}
`define IDX_REN {7'h15, 7'h14, 7'h13, 7'h12, 7'h11, 7'h10, 7'h2F, 7'h27}
`define IDX_FLAG {7'h2B, 7'h23}
`define IDX_IES {7'h2C, 7'h24}
`define IDX_IE {7'h2D, 7'h25}
`define IDX_IRQ_STAT 7'h50
`define IDX_IRQ_MASK 7'h51

`define CFG_RST 8'h00
`define SEL_P2_XTAL_RST 8'hC0

`endif

// [core/gpio_pkg.sv]
// Purpose: Shared types of the GPIO bank.
// Assumes: Eight ports of eight pins.
// Notes: Index lists from gpio_defs.svh are split with the index helper.
package gpio_pkg;
   typedef logic [6:0] idx_t;
   typedef logic [7:0][7:0] port8_t;
   typedef logic [1:0][7:0] port2_t;

   typedef struct packed {
      logic ack;
      logic from_store;
      logic [7:0] rdata;
      port8_t dir;
      port8_t sel;
      port8_t sel2;
      port8_t ren;
      port2_t flag;
      port2_t ie;
      port8_t latch;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
   } bank_t;

   typedef struct packed {
      port8_t lvl;
      port2_t ies;
      logic [7:0] rdata;
   } keep_t;

   typedef struct packed {
      port8_t s1;
      port8_t s2;
      port8_t s3;
   } sync_t;

   function automatic idx_t idx_at(input logic [55:0] list, input int p);
      idx_at = list[7 * p +: 7];
   endfunction : idx_at
endpackage : gpio_pkg

// [core/gpio_store_if.sv]
// Purpose: Carries writes and contents between the bank and its unreset store.
// Assumes: One clock.
// Notes: Contents are visible in parallel for the pin logic.
`timescale 1ns/10ps
interface gpio_store_if;
   import gpio_pkg::*;
   logic we;
   idx_t idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   port8_t lvl;
   port2_t ies;
   modport bank (output we, idx, wdata, input rdata, lvl, ies);
   modport store (input we, idx, wdata, output rdata, lvl, ies);
endinterface : gpio_store_if

// [core/gpio_sync.sv]
// Purpose: Brings the pins into the clock domain and keeps the prior sample.
// Assumes: Pins are asynchronous to REF_CLK.
// Notes: No reset, so the input register keeps its content over a reset.
`timescale 1ns/10ps
module gpio_sync
   import gpio_pkg::*;
(
   input wire logic clk_in, // system clock
   input wire logic [63:0] pin_in, // raw pin levels
   output logic [63:0] pin_out, // synchronised pin levels
   output logic [63:0] prev_out // levels one cycle earlier
);
   sync_t s_q;
   sync_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.s1 = pin_in;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
   end

   always_ff @(posedge clk_in)
   begin
      s_q <= s_d;
   end

   assign pin_out = s_q.s2;
   assign prev_out = s_q.s3;
endmodule : gpio_sync

// [core/gpio_store.sv]
// Purpose: Unreset byte store for output levels and edge polarities.
// Assumes: Writes come from the bank, already decoded as accepted.
// Notes: Read data is registered, so it is valid one edge after the index.
`timescale 1ns/10ps
`include "gpio_defs.svh"
module gpio_store
   import gpio_pkg::*;
(
   input wire logic clk_in, // system clock
   gpio_store_if.store sif // bank side
);
   localparam logic [55:0] LIST_OUT = `IDX_OUT;
   localparam logic [13:0] LIST_IES = `IDX_IES;

   keep_t k_q;
   keep_t k_d;

   always_comb
   begin
      k_d = k_q;
      k_d.rdata = 8'h00;
      for (int p = 0; p < 8; p++)
      begin
         if (sif.idx == idx_at({42'h0, LIST_IES}, p) && p < 2)
         begin
            k_d.rdata = k_q.ies[p[0]];
            if (sif.we)
            begin
               k_d.ies[p[0]] = sif.wdata;
            end
         end
         if (sif.idx == idx_at(LIST_OUT, p))
         begin
            k_d.rdata = k_q.lvl[p];
            if (sif.we)
            begin
               k_d.lvl[p] = sif.wdata;
            end
         end
      end
   end

   // Without reset on purpose: these bytes survive a power-up clear.
   always_ff @(posedge clk_in)
   begin
      k_q <= k_d;
   end

   assign sif.rdata = k_q.rdata;
   assign sif.lvl = k_q.lvl;
   assign sif.ies = k_q.ies;
endmodule : gpio_store

// [core/gpio_bank.sv]
// Purpose: Eight-port GPIO bank with Wishbone register access and pin logic.
// Assumes: Classic Wishbone, 32-bit data, registers in the low byte lane.
// Notes: Pins are flattened, port 1 in bits 7:0 up to port 8 in bits 63:56.
`timescale 1ns/10ps
`include "gpio_defs.svh"

// Function
// - Reset clears direction, flag, enable, both selects and pull enables to zero, except the port 2 function select.
// - Reset leaves pin input, output level and edge polarity bytes as they were.
// - Reset sets port 2 function select to C0h when crystal pins are shared, else 00h.
// - The pin input register is read-only and shows 0 for a low pin, 1 for a high.
// - Each output level register is 8-bit read/write with one bit per pin.
// - A pin set as output is driven low for a level bit of 0 and high for 1.
// - An input pin with pull enabled is pulled down for level 0 and up for level 1.
// - Only ports 1 and 2 have flag, edge polarity and enable registers.
// - A direction bit of 0 makes the pin an input and 1 makes it an output.
// - A set pull enable bit turns an input pin's resistor on, a clear one turns it off.
// - Select pair: 00 I/O, first only primary, both secondary, second only reserved.
// - Port 1 and 2 flags set on the rising edge for polarity 0, falling for 1.
module gpio_bank
   import gpio_pkg::*;
#(
   parameter bit XTAL_SHARED = 1'b1
)
(
   input wire logic REF_CLK_IN, // system clock, 100 MHz
   input wire logic RST_IN, // power-up clear, async, active high
   input wire logic WB_CYC_IN, // Wishbone cycle
   input wire logic WB_STB_IN, // Wishbone strobe
   input wire logic WB_WE_IN, // Wishbone write enable
   input wire logic [8:0] WB_ADR_IN, // byte address
   input wire logic [3:0] WB_SEL_IN, // byte lanes
   input wire logic [31:0] WB_DAT_IN, // write data
   output logic [31:0] WB_DAT_OUT, // read data
   output logic WB_ACK_OUT, // Wishbone acknowledge
   input wire logic [63:0] PIN_IN, // pin levels from the pads
   output logic [63:0] PIN_OUT, // pin drive levels
   output logic [63:0] PIN_OE_OUT, // pin output enables
   output logic [63:0] PULL_EN_OUT, // pull resistor enables
   output logic [63:0] PULL_UP_OUT, // pull direction, 1 up
   input wire logic [63:0] PRI_DATA_IN, // primary peripheral drive
   input wire logic [63:0] SEC_DATA_IN, // secondary peripheral drive
   output logic [63:0] PERIPH_IN_OUT, // latched pins to peripherals
   output logic [1:0] PORT_IRQ_OUT, // port 1 and 2 requests
   output logic IRQ_OUT // masked summary interrupt
);
   localparam logic [55:0] LIST_IN = `IDX_IN;
   localparam logic [55:0] LIST_DIR = `IDX_DIR;
   localparam logic [55:0] LIST_SEL = `IDX_SEL;
   localparam logic [55:0] LIST_SEL2 = `IDX_SEL2;
   localparam logic [55:0] LIST_REN = `IDX_REN;
   localparam logic [13:0] LIST_FLAG = `IDX_FLAG;
   localparam logic [13:0] LIST_IE = `IDX_IE;
   localparam logic [7:0] P2_SEL_RST = XTAL_SHARED ? `SEL_P2_XTAL_RST : `CFG_RST;

   bank_t s_q;
   bank_t s_d;

   logic [63:0] pin_q;
   logic [63:0] pin_prev;
   logic [63:0] lvl_v;
   logic [63:0] drv;
   logic [63:0] pri_m;
   logic [63:0] sec_m;
   logic [63:0] sel_any;
   logic req;
   logic wr;
   logic rd_stat;
   logic [7:0] wd;
   idx_t idx;
   port2_t edge_ev;
   logic [1:0] irq_ev;

   gpio_store_if sif ();

   gpio_sync u_sync
   (
      .clk_in(REF_CLK_IN),
      .pin_in(PIN_IN),
      .pin_out(pin_q),
      .prev_out(pin_prev)
   );

   gpio_store u_store
   (
      .clk_in(REF_CLK_IN),
      .sif(sif.store)
   );

   // A request is taken once; ack high blocks a second take of the same cycle.
   assign req = WB_CYC_IN & WB_STB_IN & ~s_q.ack;
   assign wr = req & WB_WE_IN & WB_SEL_IN[0];
   assign idx = WB_ADR_IN[8:2];
   assign wd = WB_DAT_IN[7:0];
   assign rd_stat = req & ~WB_WE_IN & (idx == `IDX_IRQ_STAT);

   assign sif.we = wr;
   assign sif.idx = idx;
   assign sif.wdata = wd;
   assign lvl_v = sif.lvl;

   // Edges of ports 1 and 2; pins handed to a peripheral raise no flag.
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         for (int b = 0; b < 8; b++)
         begin
            if (s_q.sel[p][b] | s_q.sel2[p][b])
            begin
               edge_ev[p][b] = 1'b0;
            end
            else if (sif.ies[p][b])
            begin
               edge_ev[p][b] = pin_prev[8 * p + b] & ~pin_q[8 * p + b];
            end
            else
            begin
               edge_ev[p][b] = ~pin_prev[8 * p + b] & pin_q[8 * p + b];
            end
         end
         irq_ev[p] = |(edge_ev[p] & s_q.ie[p]);
      end
   end

   always_comb
   begin
      s_d = s_q;
      s_d.ack = req;
      s_d.from_store = 1'b0;
      s_d.rdata = 8'h00;
      if (req)
      begin
         s_d.from_store = 1'b1;
         for (int p = 0; p < 8; p++)
         begin
            if (idx == idx_at(LIST_IN, p))
            begin
               s_d.from_store = 1'b0;
               s_d.rdata = pin_q[8 * p +: 8];
            end
            if (idx == idx_at(LIST_DIR, p))
            begin
               s_d.from_store = 1'b0;
               s_d.rdata = s_q.dir[p];
               if (wr)
               begin
                  s_d.dir[p] = wd;
               end
            end
            if (idx == idx_at(LIST_SEL, p))
            begin
               s_d.from_store = 1'b0;
               s_d.rdata = s_q.sel[p];
               if (wr)
               begin
                  s_d.sel[p] = wd;
               end
            end
            if (idx == idx_at(LIST_SEL2, p))
            begin
               s_d.from_store = 1'b0;
               s_d.rdata = s_q.sel2[p];
               if (wr)
               begin
                  s_d.sel2[p] = wd;
               end
            end
            if (idx == idx_at(LIST_REN, p))
            begin
               s_d.from_store = 1'b0;
               s_d.rdata = s_q.ren[p];
               if (wr)
               begin
                  s_d.ren[p] = wd;
               end
            end
         end
         for (int p = 0; p < 2; p++)
         begin
            if (idx == idx_at({42'h0, LIST_FLAG}, p))
            begin
               s_d.from_store = 1'b0;
               s_d.rdata = s_q.flag[p];
               if (wr)
               begin
                  s_d.flag[p] = wd;
               end
            end
            if (idx == idx_at({42'h0, LIST_IE}, p))
            begin
               s_d.from_store = 1'b0;
               s_d.rdata = s_q.ie[p];
               if (wr)
               begin
                  s_d.ie[p] = wd;
               end
            end
         end
         if (idx == `IDX_IRQ_STAT)
         begin
            s_d.from_store = 1'b0;
            s_d.rdata = {6'h00, s_q.irq_stat};
         end
         if (idx == `IDX_IRQ_MASK)
         begin
            s_d.from_store = 1'b0;
            s_d.rdata = {6'h00, s_q.irq_mask};
            if (wr)
            begin
               s_d.irq_mask = wd[1:0];
            end
         end
      end
      // Reading the status clears it, but an event in that cycle still lands.
      if (rd_stat)
      begin
         s_d.irq_stat = 2'b00;
      end
      s_d.irq_stat = s_d.irq_stat | irq_ev;
      // Hardware sets win over a software write in the same cycle.
      for (int p = 0; p < 2; p++)
      begin
         s_d.flag[p] = s_d.flag[p] | edge_ev[p];
      end
      // Peripheral inputs follow the pin only while a select bit is set.
      for (int b = 0; b < 64; b++)
      begin
         if (sel_any[b])
         begin
            s_d.latch[b / 8][b % 8] = pin_q[b];
         end
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         s_q <= '0;
         s_q.sel[1] <= P2_SEL_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign sel_any = s_q.sel | s_q.sel2;
   assign pri_m = s_q.sel & ~s_q.sel2;
   assign sec_m = s_q.sel & s_q.sel2;

   // The reserved code falls back to the port function as the safest choice.
   assign drv = (pri_m & PRI_DATA_IN) | (sec_m & SEC_DATA_IN) | (~s_q.sel & lvl_v);

   // Selecting a peripheral does not set direction; software still owns it.
   assign PIN_OE_OUT = s_q.dir;
   // Gated by the enable so an undefined level byte never reaches a pad.
   assign PIN_OUT = drv & s_q.dir;
   assign PULL_EN_OUT = s_q.ren & ~s_q.dir;
   assign PULL_UP_OUT = s_q.ren & ~s_q.dir & lvl_v;

   assign PERIPH_IN_OUT = s_q.latch;
   assign PORT_IRQ_OUT[0] = |(s_q.flag[0] & s_q.ie[0]);
   assign PORT_IRQ_OUT[1] = |(s_q.flag[1] & s_q.ie[1]);
   assign IRQ_OUT = |(s_q.irq_stat & s_q.irq_mask);

   assign WB_ACK_OUT = s_q.ack;
   assign WB_DAT_OUT = {24'h000000, s_q.from_store ? sif.rdata : s_q.rdata};
endmodule : gpio_bank

// [bench/gpio_bank_properties.sv]
// Purpose: Port-level checks of the GPIO bank.
// Assumes: One clock, reset active high.
// Notes: Bound to every gpio_bank instance.
`timescale 1ns/10ps
module gpio_bank_properties
(
   input wire logic REF_CLK_IN, // clock
   input wire logic RST_IN, // reset
   input wire logic WB_CYC_IN, // cycle
   input wire logic WB_STB_IN, // strobe
   input wire logic WB_WE_IN, // write
   input wire logic [8:0] WB_ADR_IN, // address
   input wire logic [3:0] WB_SEL_IN, // lanes
   input wire logic [31:0] WB_DAT_IN, // write data
   input wire logic [31:0] WB_DAT_OUT, // read data
   input wire logic WB_ACK_OUT, // ack
   input wire logic [63:0] PIN_OUT, // drive
   input wire logic [63:0] PIN_OE_OUT, // enables
   input wire logic [63:0] PULL_EN_OUT, // pulls
   input wire logic [63:0] PULL_UP_OUT, // pull up
   input wire logic [1:0] PORT_IRQ_OUT, // port requests
   input wire logic IRQ_OUT // summary
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   logic req;
   assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
   a_ack_answers: assert property (req |=> WB_ACK_OUT)
      else $error("ack missing after request");
   a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (!req |=> !WB_ACK_OUT)
      else $error("ack without request");
   a_read_upper: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_drive_gated: assert property ((PIN_OUT & ~PIN_OE_OUT) == 64'h0)
      else $error("drive level on input pin");
   a_pull_off_out: assert property ((PULL_EN_OUT & PIN_OE_OUT) == 64'h0)
      else $error("pull on output pin");
   a_pullup_gated: assert property ((PULL_UP_OUT & ~PULL_EN_OUT) == 64'h0)
      else $error("pull up without pull");
   a_dir_write: assert property (req && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN[8:2] == 7'h22
      |=> PIN_OE_OUT[7:0] == $past(WB_DAT_IN[7:0]))
      else $error("direction write not on enables");
   a_release_quiet: assert property ($fell(RST_IN) |-> !IRQ_OUT && PORT_IRQ_OUT == 2'h0)
      else $error("interrupt high after reset");
   c_write: cover property (WB_ACK_OUT && WB_WE_IN);
   c_irq: cover property (IRQ_OUT);
   c_port2: cover property ($rose(PORT_IRQ_OUT[1]));
endmodule : gpio_bank_properties
bind gpio_bank gpio_bank_properties u_props (.REF_CLK_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN,
   .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .PIN_OUT,
   .PIN_OE_OUT, .PULL_EN_OUT, .PULL_UP_OUT, .PORT_IRQ_OUT, .IRQ_OUT);

// [bench/gpio_pads.sv]
// Purpose: Pads and outside circuit seen by the GPIO bank.
// Assumes: The bench always drives the outside source.
// Notes: A driven pin beats a pull, and a pull beats the outside source.
`timescale 1ns/10ps
module gpio_pads
(
   input wire logic [63:0] pin_in, // drive level
   input wire logic [63:0] oe_in, // output enables
   input wire logic [63:0] pull_en_in, // pull enables
   input wire logic [63:0] pull_up_in, // pull direction
   input wire logic [63:0] ext_in, // outside source
   output logic [63:0] pad_out // pad level
);
   // The weak pull wins over the outside source so pulls can be read back.
   assign pad_out = (oe_in & pin_in) | (~oe_in & pull_en_in & pull_up_in)
      | (~oe_in & ~pull_en_in & ext_in);
endmodule : gpio_pads

// [bench/eight_port_gpio_bank_tb.sv]
// Purpose: Self-checking bench of the GPIO bank.
// Assumes: Crystal pins shared, so port 2 select resets to C0h.
// Notes: Byte address is four times the register index.
`timescale 1ns/10ps
module eight_port_gpio_bank_tb;
   import gpio_pkg::*;
   logic clk, rst, cyc, stb, we, ack, irq;
   logic [8:0] adr;
   logic [3:0] sel, lane;
   logic [31:0] wdat, rdat, rdat_nox;
   logic [63:0] ext, pad, pout, oe, pen, pup, pri, sec, periph;
   logic [1:0] pirq;
   logic [7:0] r, r_nox;
   int error_cnt, num_checks, cycles;
   gpio_bank #(.XTAL_SHARED(1'b1)) u_dut (.REF_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PIN_IN(pad), .PIN_OUT(pout), .PIN_OE_OUT(oe),
      .PULL_EN_OUT(pen), .PULL_UP_OUT(pup), .PRI_DATA_IN(pri), .SEC_DATA_IN(sec),
      .PERIPH_IN_OUT(periph), .PORT_IRQ_OUT(pirq), .IRQ_OUT(irq));
   // A second bank with dedicated crystal pins sees the same bus and pins.
   gpio_bank #(.XTAL_SHARED(1'b0)) u_dut_nox (.REF_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat_nox), .WB_ACK_OUT(), .PIN_IN(pad), .PIN_OUT(), .PIN_OE_OUT(),
      .PULL_EN_OUT(), .PULL_UP_OUT(), .PRI_DATA_IN(pri), .SEC_DATA_IN(sec),
      .PERIPH_IN_OUT(), .PORT_IRQ_OUT(), .IRQ_OUT());
   gpio_pads u_pads (.pin_in(pout), .oe_in(oe), .pull_en_in(pen), .pull_up_in(pup),
      .ext_in(ext), .pad_out(pad));
   always #5 clk = ~clk;
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   always @(posedge clk)
   begin
      cycles++;
      // A hung handshake ends here rather than running on.
      if (cycles == 20000)
      begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wb(input logic w, input idx_t i, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= lane;
      adr <= {i, 2'h0};
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      r = rdat[7:0];
      r_nox = rdat_nox[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic rdchk(input string what, input idx_t i, input logic [7:0] exp);
      wb(1'b0, i, 8'h00);
      chk(what, exp, r);
   endtask : rdchk
   task automatic t_reset;
      idx_t ix[10] = '{7'h22, 7'h23, 7'h25, 7'h26, 7'h41, 7'h27, 7'h2E, 7'h48, 7'h15, 7'h3D};
      foreach (ix[k]) wb(1'b1, ix[k], 8'h3F);
      wb(1'b1, 7'h21, 8'h3C);
      wb(1'b1, 7'h24, 8'h81);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      foreach (ix[k]) rdchk("reset value", ix[k], ix[k] == 7'h2E ? 8'hC0 : 8'h00);
      wb(1'b0, 7'h2E, 8'h00);
      chk("select reset no crystal", 8'h00, r_nox);
      rdchk("level kept", 7'h21, 8'h3C);
      rdchk("polarity kept", 7'h24, 8'h81);
   endtask : t_reset
   task automatic t_drive;
      logic [7:0] e;
      wb(1'b1, 7'h1A, 8'hFF);
      wb(1'b1, 7'h19, 8'hA5);
      rdchk("level read", 7'h19, 8'hA5);
      chk("output enable", 8'hFF, oe[23:16]);
      for (int c = 0; c < 4; c++)
      begin
         wb(1'b1, 7'h1B, c[0] ? 8'hFF : 8'h00);
         wb(1'b1, 7'h43, c[1] ? 8'hFF : 8'h00);
         repeat (2) @(posedge clk);
         e = c == 1 ? pri[23:16] : c == 3 ? sec[23:16] : 8'hA5;
         chk("pin drive", e, pout[23:16]);
      end
      repeat (3) @(posedge clk);
      chk("peripheral input", 8'h5A, periph[23:16]);
      // The level matches the secondary drive so the pad holds while selects clear.
      wb(1'b1, 7'h19, 8'h5A);
      wb(1'b1, 7'h1B, 8'h00);
      wb(1'b1, 7'h43, 8'h00);
      wb(1'b1, 7'h19, 8'hA5);
      repeat (4) @(posedge clk);
      chk("peripheral hold", 8'h5A, periph[23:16]);
      chk("pin drive", 8'hA5, pout[23:16]);
   endtask : t_drive
   task automatic t_pull;
      wb(1'b1, 7'h11, 8'hFF);
      wb(1'b1, 7'h1D, 8'h0F);
      repeat (4) @(posedge clk);
      chk("pull enable", 8'hFF, pen[31:24]);
      chk("pull up", 8'h0F, pup[31:24]);
      rdchk("pin input", 7'h1C, 8'h0F);
      wb(1'b1, 7'h11, 8'h00);
      ext[31:24] <= 8'h96;
      repeat (4) @(posedge clk);
      rdchk("pin input", 7'h1C, 8'h96);
      wb(1'b1, 7'h1C, 8'h00);
      rdchk("input after write", 7'h1C, 8'h96);
      rdchk("level after write", 7'h1D, 8'h0F);
      lane = 4'hE;
      wb(1'b1, 7'h1D, 8'hFF);
      lane = 4'h1;
      rdchk("level lane off", 7'h1D, 8'h0F);
      chk("no port 4 request", 2'h0, pirq);
      rdchk("unmapped", 7'h4F, 8'h00);
   endtask : t_pull
   task automatic t_irq;
      wb(1'b1, 7'h24, 8'h00);
      wb(1'b1, 7'h2C, 8'h01);
      wb(1'b1, 7'h25, 8'h01);
      wb(1'b1, 7'h2D, 8'h01);
      wb(1'b1, 7'h51, 8'h01);
      wb(1'b1, 7'h23, 8'h00);
      wb(1'b1, 7'h2B, 8'h00);
      wb(1'b0, 7'h50, 8'h00);
      ext[0] <= 1'b1;
      repeat (5) @(posedge clk);
      rdchk("port 1 rising", 7'h23, 8'h01);
      chk("port request", 2'h1, pirq);
      chk("irq raised", 1'b1, irq);
      rdchk("irq status", 7'h50, 8'h01);
      repeat (2) @(posedge clk);
      chk("irq cleared", 1'b0, irq);
      ext[8] <= 1'b0;
      repeat (5) @(posedge clk);
      rdchk("port 2 falling", 7'h2B, 8'h01);
      chk("port request", 2'h3, pirq);
      chk("irq masked", 1'b0, irq);
      wb(1'b1, 7'h23, 8'h00);
      wb(1'b1, 7'h2B, 8'h00);
      repeat (2) @(posedge clk);
      chk("flags cleared", 2'h0, pirq);
   endtask : t_irq
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      {cyc, stb, we} = 3'h0;
      adr = 9'h000;
      sel = 4'h1;
      lane = 4'h1;
      wdat = 32'h0;
      ext = 64'h0000_0000_0000_0100;
      pri = 64'h3C3C_3C3C_3C3C_3C3C;
      sec = 64'h5A5A_5A5A_5A5A_5A5A;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_drive();
      t_pull();
      t_irq();
      end_sim();
   end
endmodule : eight_port_gpio_bank_tb
